// ==== rtl/shift_logic_defines.svh ====
// Purpose: Constants for the shift and logic unit
// Assumes: 8-bit data path
`ifndef SHIFT_LOGIC_DEFINES_SVH
`define SHIFT_LOGIC_DEFINES_SVH
`define SLU_DATA_W       8
`define SLU_MSB          7
`define SLU_NIB_HI       7:4
`define SLU_NIB_LO       3:0
`define SLU_ACC_RST      8'h00
`define SLU_FLAG_RST     4'h0
`define SLU_LATENCY      1
`endif

// ==== rtl/shift_logic_pkg.sv ====
// Purpose: Types for the shift and logic unit
// Assumes: Opcodes come from the core's decoder
// Notes:   One-hot free encoding of operations
package shift_logic_pkg;
	typedef enum logic [4:0] {
		OP_NONE      = 5'h00,
		OP_SR_ACC    = 5'h01,
		OP_SRC_ACC   = 5'h02,
		OP_SR_MEM    = 5'h03,
		OP_SRC_MEM   = 5'h04,
		OP_SL_ACC    = 5'h05,
		OP_SLC_ACC   = 5'h06,
		OP_SL_MEM    = 5'h07,
		OP_SLC_MEM   = 5'h08,
		OP_SWAP_ACC  = 5'h09,
		OP_AND_ACC_I = 5'h0A,
		OP_AND_ACC_M = 5'h0B,
		OP_AND_MEM   = 5'h0C,
		OP_OR_ACC_I  = 5'h0D,
		OP_OR_ACC_M  = 5'h0E,
		OP_OR_MEM    = 5'h0F,
		OP_XOR_ACC_I = 5'h10,
		OP_XOR_IO    = 5'h11
	} slu_op_t;

	typedef struct packed {
		logic zero;
		logic carry;
		logic halfFlag;
		logic signedFlowFlag;
	} slu_flags_t;

	typedef struct packed {
		logic       valid;
		slu_op_t    op;
		logic [7:0] operand;
	} slu_req_t;

	typedef struct packed {
		logic       accWrite;
		logic       memWrite;
		logic       ioWrite;
		logic [7:0] data;
	} slu_res_t;
endpackage

// ==== rtl/slu_shifter.sv ====
// Purpose: One-place shift or rotate of a byte
// Assumes: Purely combinational
// Notes:   Rotate goes through the carry input
`timescale 1ns/1ps
`include "shift_logic_defines.svh"
module slu_shifter
	import shift_logic_pkg::*;
#(
	parameter int DATA_W = `SLU_DATA_W
)(
	input  wire logic [DATA_W-1:0] dataIn,
	input  wire logic              leftDir,
	input  wire logic              throughCarry,
	input  wire logic              carryIn,
	output logic      [DATA_W-1:0] dataOut,
	output logic                   carryOut
);
	initial
	begin
		if (DATA_W < 2)
			$error("slu_shifter: DATA_W too small");
	end

	logic fillBit;
	assign fillBit = throughCarry ? carryIn : 1'b0;

	always_comb
	begin
		if (leftDir)
		begin
			dataOut  = {dataIn[DATA_W-2:0], fillBit};
			carryOut = dataIn[DATA_W-1];
		end
		else
		begin
			dataOut  = {fillBit, dataIn[DATA_W-1:1]};
			carryOut = dataIn[0];
		end
	end
endmodule

// ==== rtl/slu_logic.sv ====
// Purpose: Bitwise AND, OR, XOR and nibble swap
// Assumes: Purely combinational
// Notes:   Zero test always computed, used only by logic ops
`timescale 1ns/1ps
`include "shift_logic_defines.svh"
module slu_logic
	import shift_logic_pkg::*;
#(
	parameter int DATA_W = `SLU_DATA_W
)(
	input  wire logic [DATA_W-1:0] opA,
	input  wire logic [DATA_W-1:0] opB,
	input  wire logic [1:0]        func,
	output logic      [DATA_W-1:0] result,
	output logic                   isZero
);
	initial
	begin
		if (DATA_W != 8)
			$error("slu_logic: nibble swap needs DATA_W of 8");
	end

	always_comb
	begin
		unique case (func)
			2'h0: result = opA & opB;
			2'h1: result = opA | opB;
			2'h2: result = opA ^ opB;
			2'h3: result = {opA[`SLU_NIB_LO], opA[`SLU_NIB_HI]};
		endcase
	end

	assign isZero = (result == '0);
endmodule

// ==== rtl/shift_logic_unit.sv ====
// Purpose: Shift, rotate, swap and logic unit of the core
// Assumes: Decoder presents one request per cycle with operands
// Notes:   Result and flags appear one cycle after the request
//
// Summary of operation
// - Right shift working register, zero fill, carry
// - Right rotate working register through carry
// - Right shift memory byte, zero fill, carry
// - Right rotate memory byte through carry
// - Left shift working register, zero fill, carry
// - Left rotate working register through carry
// - Left shift memory byte, zero fill, carry
// - Left rotate memory byte through carry
// - Swap nibbles of working register, no flags
// - AND immediate into working register, zero flag
// - AND memory into working register, zero flag
// - AND working register into memory, zero flag
// - OR immediate into working register, zero flag
// - OR memory into working register, zero flag
// - OR working register into memory, zero flag
// - XOR immediate into working register, zero flag
// - XOR working register into I/O register
`timescale 1ns/1ps
`include "shift_logic_defines.svh"
module shift_logic_unit
	import shift_logic_pkg::*;
#(
	parameter int DATA_W = `SLU_DATA_W
)(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire slu_req_t          req,
	input  wire logic [DATA_W-1:0] memData,
	input  wire logic [DATA_W-1:0] ioData,
	input  wire slu_flags_t        flagsIn,
	output slu_flags_t             flagsOut,
	output logic [DATA_W-1:0]      working_register,
	output slu_res_t               result,
	output logic                   done
);
	initial
	begin
		if (DATA_W != 8)
			$error("shift_logic_unit: only an 8-bit path is supported");
	end

	// Flags come from flagsIn on every request; flags_reg only registers the updated copy
	slu_flags_t        flags_reg;
	slu_flags_t        flags_next;
	logic [DATA_W-1:0] acc_reg;
	logic [DATA_W-1:0] acc_next;
	slu_res_t          res_reg;
	slu_res_t          res_next;
	logic              done_reg;

	logic [DATA_W-1:0] shiftIn;
	logic              shiftLeft;
	logic              shiftRot;
	logic [DATA_W-1:0] shiftOut;
	logic              shiftCarry;
	logic [DATA_W-1:0] logicB;
	logic [1:0]        logicFunc;
	logic [DATA_W-1:0] logicOut;
	logic              logicZero;

	function automatic logic isMemShift(input slu_op_t op);
		return op inside {OP_SR_MEM, OP_SRC_MEM, OP_SL_MEM, OP_SLC_MEM};
	endfunction

	// Operand and direction selection for the shifter
	always_comb
	begin
		shiftIn   = isMemShift(req.op) ? memData : acc_reg;
		shiftLeft = req.op inside {OP_SL_ACC, OP_SLC_ACC, OP_SL_MEM, OP_SLC_MEM};
		shiftRot  = req.op inside {OP_SRC_ACC, OP_SRC_MEM, OP_SLC_ACC, OP_SLC_MEM};
	end

	slu_shifter #(
		.DATA_W       (DATA_W)
	) u_shifter (
		.dataIn       (shiftIn),
		.leftDir      (shiftLeft),
		.throughCarry (shiftRot),
		.carryIn      (flagsIn.carry),
		.dataOut      (shiftOut),
		.carryOut     (shiftCarry)
	);

	// Second operand and function for the logic block
	always_comb
	begin
		logicB    = memData;
		logicFunc = 2'h0;
		unique case (req.op)
			OP_AND_ACC_I, OP_OR_ACC_I, OP_XOR_ACC_I:
				logicB = req.operand;
			OP_XOR_IO:
				logicB = ioData;
			default:
				logicB = memData;
		endcase
		unique case (req.op)
			OP_OR_ACC_I, OP_OR_ACC_M, OP_OR_MEM:
				logicFunc = 2'h1;
			OP_XOR_ACC_I, OP_XOR_IO:
				logicFunc = 2'h2;
			OP_SWAP_ACC:
				logicFunc = 2'h3;
			default:
				logicFunc = 2'h0;
		endcase
	end

	slu_logic #(
		.DATA_W (DATA_W)
	) u_logic (
		.opA    (acc_reg),
		.opB    (logicB),
		.func   (logicFunc),
		.result (logicOut),
		.isZero (logicZero)
	);

	// Result routing and flag updates
	always_comb
	begin
		acc_next   = acc_reg;
		flags_next = flagsIn;
		res_next   = '0;
		if (req.valid)
		begin
			unique case (req.op)
				OP_SR_ACC, OP_SL_ACC:
				begin
					acc_next         = shiftOut;
					flags_next.carry = shiftCarry;
				end
				OP_SRC_ACC, OP_SLC_ACC:
				begin
					acc_next         = shiftOut;
					flags_next.carry = shiftCarry;
				end
				OP_SR_MEM, OP_SL_MEM:
				begin
					res_next.memWrite = 1'b1;
					res_next.data     = shiftOut;
					flags_next.carry  = shiftCarry;
				end
				OP_SRC_MEM, OP_SLC_MEM:
				begin
					res_next.memWrite = 1'b1;
					res_next.data     = shiftOut;
					flags_next.carry  = shiftCarry;
				end
				OP_SWAP_ACC:
					acc_next = logicOut;
				OP_AND_ACC_I, OP_AND_ACC_M:
				begin
					acc_next        = logicOut;
					flags_next.zero = logicZero;
				end
				OP_AND_MEM:
				begin
					res_next.memWrite = 1'b1;
					res_next.data     = logicOut;
					flags_next.zero   = logicZero;
				end
				OP_OR_ACC_I, OP_OR_ACC_M:
				begin
					acc_next        = logicOut;
					flags_next.zero = logicZero;
				end
				OP_OR_MEM:
				begin
					res_next.memWrite = 1'b1;
					res_next.data     = logicOut;
					flags_next.zero   = logicZero;
				end
				OP_XOR_ACC_I:
				begin
					acc_next        = logicOut;
					flags_next.zero = logicZero;
				end
				OP_XOR_IO:
				begin
					// Flags left alone; the I/O form names no flag effect
					res_next.ioWrite = 1'b1;
					res_next.data    = logicOut;
				end
				default:
				begin
					acc_next   = acc_reg;
					flags_next = flagsIn;
				end
			endcase
			res_next.accWrite = (acc_next != acc_reg) ||
				req.op inside {OP_SR_ACC, OP_SRC_ACC, OP_SL_ACC, OP_SLC_ACC,
				OP_SWAP_ACC, OP_AND_ACC_I, OP_AND_ACC_M, OP_OR_ACC_I,
				OP_OR_ACC_M, OP_XOR_ACC_I};
			if (res_next.accWrite)
				res_next.data = acc_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			acc_reg <= `SLU_ACC_RST;
		else
			acc_reg <= acc_next;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_reg <= slu_flags_t'(`SLU_FLAG_RST);
		else if (req.valid)
			flags_reg <= flags_next;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_reg  <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			res_reg  <= res_next;
			done_reg <= req.valid;
		end
	end

	assign flagsOut         = flags_reg;
	assign working_register = acc_reg;
	assign result           = res_reg;
	assign done             = done_reg;
endmodule

// ==== tb/shift_logic_unit_props.sv ====
// Purpose: Port checks of the shift and logic unit
// Assumes: Answer exactly one cycle after a taken request
// Notes:   Sees only the unit's ports
`timescale 1ns/1ps
module shift_logic_unit_props
	import shift_logic_pkg::*;
#(
	parameter int DATA_W = 8
)(
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire slu_req_t          req,
	input wire logic [DATA_W-1:0] memData,
	input wire logic [DATA_W-1:0] ioData,
	input wire slu_flags_t        flagsIn,
	input wire slu_flags_t        flagsOut,
	input wire logic [DATA_W-1:0] working_register,
	input wire slu_res_t          result,
	input wire logic              done
);
	wire logic       v = req.valid;
	wire logic [7:0] acc = working_register;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	AST_SR_ACC: assert property (v && req.op == OP_SR_ACC |=> acc == $past(acc) >> 1
		&& flagsOut == {$past(flagsIn.zero), $past(acc[0]), $past(flagsIn[1:0])})
		else $error("right shift of acc wrong");
	AST_SRC_ACC: assert property (v && req.op == OP_SRC_ACC |=>
		acc == {$past(flagsIn.carry), $past(acc[7:1])} && flagsOut.carry == $past(acc[0]))
		else $error("right rotate of acc wrong");
	AST_SR_MEM: assert property (v && req.op == OP_SR_MEM |=> result.memWrite
		&& result.data == $past(memData) >> 1 && flagsOut.carry == $past(memData[0]))
		else $error("right shift of memory wrong");
	AST_SL_ACC: assert property (v && req.op == OP_SL_ACC |=> acc == $past(acc) << 1
		&& flagsOut.carry == $past(acc[7]) && flagsOut.zero == $past(flagsIn.zero))
		else $error("left shift of acc wrong");
	AST_SLC_MEM: assert property (v && req.op == OP_SLC_MEM |=>
		result.data == {$past(memData[6:0]), $past(flagsIn.carry)} && flagsOut.carry == $past(memData[7]))
		else $error("left rotate of memory wrong");
	AST_SWAP: assert property (v && req.op == OP_SWAP_ACC |=>
		acc == {$past(acc[3:0]), $past(acc[7:4])} && flagsOut == $past(flagsIn))
		else $error("nibble swap wrong");
	AST_AND_MEM: assert property (v && req.op == OP_AND_MEM |=>
		result.data == ($past(acc) & $past(memData)) && flagsOut.zero == (result.data == 8'h00))
		else $error("and into memory wrong");
	AST_OR_IMM: assert property (v && req.op == OP_OR_ACC_I |=>
		acc == ($past(acc) | $past(req.operand)) && !result.memWrite)
		else $error("or immediate wrong");
	AST_XOR_IO: assert property (v && req.op == OP_XOR_IO |=> result.ioWrite
		&& result.data == ($past(acc) ^ $past(ioData)) && acc == $past(acc))
		else $error("xor into io wrong");
	AST_DONE: assert property (done == $past(v))
		else $error("done not one cycle after request");
	cover property (v && req.op == OP_SLC_MEM);
	cover property (v ##1 v ##1 v);
	cover property (result.ioWrite && result.data == 8'h00);
endmodule

// ==== tb/slu_operand_source.sv ====
// Purpose: Operand fetch side facing the unit
// Assumes: Operands only meaningful while a request is presented
// Notes:   Idle outputs show changing garbage
`timescale 1ns/1ps
module slu_operand_source
	import shift_logic_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       present,
	input  wire logic [7:0] memSet,
	input  wire logic [7:0] ioSet,
	input  wire slu_flags_t flagSet,
	output logic [7:0]      memData,
	output logic [7:0]      ioData,
	output slu_flags_t      flagsIn
);
	logic [19:0] junk_reg = 20'hA5C3F;
	// Inverse of last value so a stale read never matches
	always_ff @(posedge sys_clk)
		junk_reg <= ~{memData, ioData, flagsIn};
	assign {memData, ioData, flagsIn} = present ? {memSet, ioSet, flagSet} : junk_reg;
endmodule

// ==== tb/shift_logic_unit_tb_top.sv ====
// Purpose: Self-checking bench of the shift and logic unit
// Assumes: Inputs change at the falling edge
// Notes:   Expectations queued by the driver, popped on done
`timescale 1ns/1ps
module shift_logic_unit_tb_top
	import shift_logic_pkg::*;
;
	typedef struct packed {logic [7:0] a; slu_flags_t f; slu_res_t r;} exp_t;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	slu_req_t    req = '0;
	logic [7:0]  memSet = 8'h00;
	logic [7:0]  ioSet = 8'h00;
	slu_flags_t  flagSet = '0;
	logic [7:0]  memData, ioData, working_register;
	slu_flags_t  flagsIn, flagsOut;
	slu_res_t    result;
	logic        done;
	logic [7:0]  acc = 8'h00;
	logic [31:0] seed = 32'h0000004B;
	int          num_errors = 0, num_checks = 0, cycles = 0;
	exp_t        expQ[$];
	exp_t        e;

	shift_logic_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .memData(memData),
		.ioData(ioData), .flagsIn(flagsIn), .flagsOut(flagsOut),
		.working_register(working_register), .result(result), .done(done));
	slu_operand_source far (.sys_clk(sys_clk), .present(req.valid), .memSet(memSet),
		.ioSet(ioSet), .flagSet(flagSet), .memData(memData), .ioData(ioData), .flagsIn(flagsIn));

	initial
		forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			results();
		end
	end

	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic bad(logic [10:0] g, logic [10:0] x);
		num_errors++;
		$display("[ERR] %0t got %h exp %h", $time, g, x);
	endtask
	task automatic cmpAcc(logic [7:0] g, logic [7:0] x);
		num_checks++;
		if (g !== x) bad(11'(g), 11'(x));
	endtask
	task automatic cmpFlags(slu_flags_t g, slu_flags_t x);
		num_checks++;
		if (g !== x) bad(11'(g), 11'(x));
	endtask
	task automatic cmpRes(slu_res_t g, slu_res_t x);
		num_checks++;
		if (g !== x) bad(g, x);
	endtask
	task automatic results();
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic issue(slu_op_t o);
		logic [7:0] na, imm, mem, io;
		slu_flags_t nf;
		slu_res_t   r;
		@(negedge sys_clk);
		seed = xs(seed);
		// Zero operands often, so the zero flag gets set
		{io, mem, imm} = seed[30:29] == 2'h0 ? 24'h0 : seed[23:0];
		nf = slu_flags_t'(seed[27:24]);
		na = acc;
		r = '0;
		case (o)
			OP_SR_ACC:    {na, nf.carry} = {1'b0, acc};
			OP_SRC_ACC:   {na, nf.carry} = {seed[26], acc};
			OP_SR_MEM:    {r.data, nf.carry} = {1'b0, mem};
			OP_SRC_MEM:   {r.data, nf.carry} = {seed[26], mem};
			OP_SL_ACC:    {nf.carry, na} = {acc, 1'b0};
			OP_SLC_ACC:   {nf.carry, na} = {acc, seed[26]};
			OP_SL_MEM:    {nf.carry, r.data} = {mem, 1'b0};
			OP_SLC_MEM:   {nf.carry, r.data} = {mem, seed[26]};
			OP_SWAP_ACC:  na = {acc[3:0], acc[7:4]};
			OP_AND_ACC_I: na = acc & imm;
			OP_AND_ACC_M: na = acc & mem;
			OP_AND_MEM:   r.data = acc & mem;
			OP_OR_ACC_I:  na = acc | imm;
			OP_OR_ACC_M:  na = acc | mem;
			OP_OR_MEM:    r.data = acc | mem;
			OP_XOR_ACC_I: na = acc ^ imm;
			OP_XOR_IO:    r.data = acc ^ io;
			default:      ;
		endcase
		r.memWrite = o inside {OP_SR_MEM, OP_SRC_MEM, OP_SL_MEM, OP_SLC_MEM, OP_AND_MEM, OP_OR_MEM};
		r.ioWrite = (o == OP_XOR_IO);
		r.accWrite = !r.memWrite && !r.ioWrite && o != OP_NONE;
		if (r.accWrite) r.data = na;
		if (o inside {[OP_AND_ACC_I:OP_XOR_ACC_I]}) nf.zero = (r.data == 8'h00);
		req = '{1'b1, o, imm};
		{memSet, ioSet, flagSet} = {mem, io, seed[27:24]};
		expQ.push_back('{na, nf, r});
		acc = na;
		if (seed[31])
		begin
			@(negedge sys_clk);
			req.valid = 1'b0;
		end
	endtask
	task automatic drain();
		@(negedge sys_clk);
		req.valid = 1'b0;
		repeat (2) @(negedge sys_clk);
		cmpAcc(8'(expQ.size()), 8'h00);
	endtask
	task automatic doReset();
		rst_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		cmpAcc(working_register, 8'h00);
		cmpFlags(flagsOut, '0);
		cmpRes(result, '0);
		cmpAcc({7'h00, done}, 8'h00);
		acc = 8'h00;
		rst_n = 1'b1;
	endtask

	always @(negedge sys_clk)
		if (done === 1'b1)
		begin
			if (expQ.size() == 0)
				bad(11'h000, 11'h7FF);
			else
			begin
				e = expQ.pop_front();
				cmpAcc(working_register, e.a);
				cmpFlags(flagsOut, e.f);
				cmpRes(result, e.r);
			end
		end

	initial
	begin
		doReset();
		for (int k = 0; k < 3; k++)
			for (int o = 0; o <= 17; o++)
				issue(slu_op_t'(5'(o)));
		drain();
		doReset();
		repeat (300) issue(slu_op_t'(5'(seed[7:0] % 18)));
		drain();
		results();
	end
endmodule

bind shift_logic_unit shift_logic_unit_props #(.DATA_W(DATA_W)) props (.sys_clk(sys_clk),
	.rst_n(rst_n), .req(req), .memData(memData), .ioData(ioData), .flagsIn(flagsIn),
	.flagsOut(flagsOut), .working_register(working_register), .result(result), .done(done));
